// >>> dv/midsp_host_model.sv
`timescale 1ns/1ps
module midsp_host_model
(
    input  wire logic clk,       // Bench clock
    input  wire logic sda_line,  // Resolved data line
    output logic      scl,       // Serial clock, idle high
    output logic      sda_pull,  // Host pulls data low
    output logic      res_stb,   // Result ready
    output logic [7:0] res_val   // Ack bit or read byte
);
    localparam int QTR = 2;  // Bench clocks per quarter of a 200 ns serial period

    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
        res_stb  = 1'b0;
        res_val  = 8'h00;
    end

    // Every pin change lands on a falling bench clock edge
    task automatic quarter();
        repeat (QTR) @(negedge clk);
    endtask

    task automatic report(input logic [7:0] v);
        res_val = v;
        res_stb = 1'b1;
        @(negedge clk);
        res_stb = 1'b0;
    endtask

    // Data moves only while clock low
    task automatic bit_x(input logic b, output logic seen);
        quarter();
        sda_pull = ~b;
        quarter();
        scl = 1'b1;
        quarter();
        seen = sda_line;
        quarter();
        scl = 1'b0;
    endtask

    task automatic start();
        quarter();
        sda_pull = 1'b0;
        quarter();
        scl = 1'b1;
        quarter();
        sda_pull = 1'b1;
        quarter();
        scl = 1'b0;
    endtask

    task automatic stop();
        quarter();
        sda_pull = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        sda_pull = 1'b0;
        quarter();
    endtask

    task automatic write_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], s);
        bit_x(1'b1, s);
        report({7'h00, s});
    endtask

    task automatic read_byte(input logic last);
        logic [7:0] v;
        logic       s;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, v[i]);
        bit_x(last, s);
        report(v);
    endtask
endmodule // midsp_host_model

// >>> dv/midsp_tb.sv
`timescale 1ns/1ps
module midsp_tb
    import midsp_pkg::*;
;
    logic        clk;
    logic        reset_n;
    logic        scl;
    logic        host_pull;
    logic        sda_o;
    logic        sda_oe;
    logic        present_n;
    midsp_diag_t diag_i;
    logic        cal_ext_i;
    midsp_wr_t   prog_i;
    logic        res_stb;
    logic [7:0]  res_val;
    logic [7:0]  exp_q[$];
    logic [7:0]  shadow[0:511];
    logic        prev_oe;
    int          err_total;
    int          tests_run;
    logic [8:0]  ld[7] = '{9'h0FE, 9'h0FF, 9'h000, 9'h001, 9'h010, 9'h080, 9'h180};
    logic [6:0]  bad[2] = '{7'h52, 7'h10};
    wire logic   sda_line = ~((sda_oe & ~sda_o) | host_pull);

    midsp_top uut (.clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .present_n(present_n), .diag_i(diag_i), .cal_ext_i(cal_ext_i), .prog_i(prog_i));
    midsp_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(host_pull),
        .res_stb(res_stb), .res_val(res_val));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Flags as {hi,lo} per reading, k=0 alarm limits, k=2 warn limits
    function automatic logic [9:0] flag_vec(input int k);
        logic [9:0]  f;
        logic [15:0] v;
        for (int p = 0; p < MIDSP_NPAR; p++)
        begin
            v = diag_i[79 - 16 * p -: 16];
            f[9 - 2 * p] = v > MIDSP_THR[p][k];
            f[8 - 2 * p] = v < MIDSP_THR[p][k + 1];
        end
        return f;
    endfunction

    function automatic logic [7:0] exp_byte(input logic pg, input logic [7:0] off);
        logic [9:0] a;
        logic [9:0] w;
        a = flag_vec(0);
        w = flag_vec(2);
        if (!pg || off >= MIDSP_WP_LIMIT)
            return shadow[{pg, off}];
        if (off < MIDSP_THR_END)
            return off[0] ? MIDSP_THR[off[5:3]][off[2:1]][7:0] : MIDSP_THR[off[5:3]][off[2:1]][15:8];
        if (off >= MIDSP_LIVE_BASE && off < MIDSP_LIVE_END)
            return diag_i[79 - 8 * int'(off - MIDSP_LIVE_BASE) -: 8];
        case (off)
            MIDSP_STATUS_OFF:        return {7'h00, cal_ext_i};
            MIDSP_ALARM_OFF:         return a[9:2];
            MIDSP_ALARM_OFF + 8'h01: return {a[1:0], 6'h00};
            MIDSP_WARN_OFF:          return w[9:2];
            MIDSP_WARN_OFF + 8'h01:  return {w[1:0], 6'h00};
            default:                 return 8'h00;
        endcase
    endfunction

    task automatic load(input logic [8:0] a);
        logic [7:0] d;
        d = 8'($urandom);
        shadow[a] = d;
        @(negedge clk);
        prog_i = '{1'b1, a, d};
        @(negedge clk);
        prog_i.we = 1'b0;
    endtask

    task automatic wr_b(input logic [7:0] b, input logic [7:0] ack);
        exp_q.push_back(ack);
        host.write_byte(b);
    endtask

    task automatic rd_b(input logic [7:0] e, input logic last);
        exp_q.push_back(e);
        host.read_byte(last);
    endtask

    task automatic set_ptr(input logic pg, input logic [7:0] p);
        host.start();
        wr_b({pg ? MIDSP_DIAG_ADDR : MIDSP_ID_ADDR, 1'b0}, 8'h00);
        wr_b(p, 8'h00);
    endtask

    task automatic wr_seq(input logic pg, input logic [7:0] p, input int n);
        logic [7:0] d;
        set_ptr(pg, p);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            wr_b(d, 8'h00);
            if (p >= MIDSP_WP_LIMIT)
                shadow[{pg, p}] = d;
            p++;
        end
        host.stop();
    endtask

    task automatic rd_seq(input logic pg, input logic [7:0] p, input int n);
        set_ptr(pg, p);
        host.start();
        wr_b({pg ? MIDSP_DIAG_ADDR : MIDSP_ID_ADDR, 1'b1}, 8'h00);
        for (int i = 0; i < n; i++)
        begin
            rd_b(exp_byte(pg, p), i == n - 1);
            p++;
        end
        host.stop();
    endtask

    always @(posedge clk)
    begin
        if (res_stb)
            check(res_val, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
    end

    // Drive changes must land while the serial clock is low
    always @(negedge clk)
    begin
        if (reset_n && sda_oe !== prev_oe)
            check({7'h00, scl}, 8'h00);
        prev_oe = sda_oe;
    end

    initial
    begin
        #2ms;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end

    initial
    begin
        reset_n   = 1'b0;
        diag_i    = '0;
        cal_ext_i = 1'b0;
        prog_i    = '0;
        prev_oe   = 1'b0;
        err_total = 0;
        tests_run = 0;
        void'($urandom(32'hDF12));
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        check({7'h00, present_n}, 8'h00);
        check({7'h00, sda_oe}, 8'h00);
        repeat (3) @(negedge clk);
        foreach (ld[i])
            load(ld[i]);
        $display("test reset and load done");
        rd_seq(1'b0, 8'hFE, 4);
        wr_seq(1'b0, 8'hFF, 2);
        wr_seq(1'b0, 8'h10, 1);
        wr_seq(1'b1, 8'h7F, 2);
        rd_seq(1'b0, 8'hFE, 4);
        rd_seq(1'b0, 8'h10, 1);
        rd_seq(1'b0, 8'h80, 1);
        rd_seq(1'b1, 8'h80, 1);
        $display("test memory access done");
        for (int k = 0; k < 3; k++)
        begin
            @(negedge clk);
            diag_i    = (k == 0) ? '0 : (k == 1) ? '1 : midsp_diag_t'({$urandom, $urandom, 16'($urandom)});
            cal_ext_i = k[0];
            repeat (4) @(negedge clk);
            rd_seq(1'b1, MIDSP_LIVE_BASE, 22);
        end
        rd_seq(1'b1, 8'h00, 40);
        $display("test diagnostics done");
        foreach (bad[i])
        begin
            host.start();
            wr_b({bad[i], 1'b0}, 8'h01);
            host.stop();
        end
        rd_seq(1'b0, 8'h80, 1);
        $display("test refusal done");
        check(8'(exp_q.size()), 8'h00);
        check({7'h00, present_n}, 8'h00);
        check({7'h00, sda_o}, 8'h00);
        conclude();
    end
endmodule // midsp_tb

// >>> hw/midsp_mem.sv
`timescale 1ns/1ps
module midsp_mem
    import midsp_pkg::*;
(
    input  wire logic                    clk,    // System clock
    input  wire midsp_wr_t               wr,     // Write port
    input  wire logic [MIDSP_MEM_AW-1:0] raddr,  // Read address
    output logic [7:0]                   rdata   // Registered read data
);

    logic [7:0] mem_reg [MIDSP_MEM_DEPTH];
    logic [7:0] rdata_reg;

    always_ff @(posedge clk)
    begin
        if (wr.we)
        begin
            mem_reg[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk)
    begin
        rdata_reg <= mem_reg[raddr];
    end

    assign rdata = rdata_reg;

endmodule // midsp_mem

// >>> hw/midsp_top.sv
// Notes on behaviour
// - Answer at 1010000X, serve 256-byte identification map.
// - Diagnostics at 1010001X; identification map untouched.
// - Sample on rising edge; protected bytes written only by factory load.
// - Drive data changes after falling clock edge.
// - Open-drain data line; detect start and stop.
// - Byte words, single or sequential access.
// - Live readings of five monitored values readable.
// - Alarm and warning flags on out-of-range readings.
// - Values internally calibrated unless configured otherwise.
// - Presence pin held low permanently.
`timescale 1ns/1ps
module midsp_top
    import midsp_pkg::*;
(
    input  wire logic        clk,          // 40 MHz system clock
    input  wire logic        reset_n,      // Synchronous reset
    input  wire logic        scl_i,        // Serial clock from host
    input  wire logic        sda_i,        // Serial data line level
    output logic             sda_o,        // Data drive value, always low
    output logic             sda_oe,       // Pull data line low
    output logic             present_n,    // Module present, low
    input  wire midsp_diag_t diag_i,       // Live calibrated readings
    input  wire logic        cal_ext_i,    // External calibration selected
    input  wire midsp_wr_t   prog_i        // Factory memory load port
);

    logic [0:4][15:0] live_arr;
    logic             scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic             sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic             scl_rise, scl_fall, start_det, stop_det;
    midsp_state_t     state_reg;
    logic [3:0]       bit_cnt_reg;
    logic [7:0]       shift_reg, tx_shift_reg, ptr_reg, rd_byte;
    logic             sda_oe_reg, sda_o_reg, present_n_reg;
    logic             sel_diag_reg, first_reg, ack_ok_reg, cal_ext_reg;
    logic             dev_done, rx_done, tx_done, addr_hit;
    midsp_diag_t      live_reg;
    midsp_flags_t     flags_reg;
    wire logic [0:4]  ahi_w, alo_w, whi_w, wlo_w;
    logic [15:0]      alarm_bytes, warn_bytes;
    midsp_wr_t        wr;
    logic [7:0]       mem_rdata;

    function automatic logic [7:0] word_byte(input logic [15:0] w, input logic lsb);
        return lsb ? w[7:0] : w[15:8];
    endfunction

    function automatic logic [15:0] flag_pair(input logic [0:4] hi, input logic [0:4] lo);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < MIDSP_NPAR; i++)
        begin
            r[15-2*i] = hi[i];
            r[14-2*i] = lo[i];
        end
        return r;
    endfunction

    // Two-stage synchronisers for the pins
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_meta_reg <= scl_i;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_i;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
    assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
    assign stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

    assign dev_done = (state_reg == ST_DEV) && scl_fall && (bit_cnt_reg == MIDSP_BITS_BYTE);
    assign rx_done  = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == MIDSP_BITS_BYTE);
    assign tx_done  = (state_reg == ST_TX) && scl_fall && (bit_cnt_reg == MIDSP_LAST_BIT);
    assign addr_hit = (shift_reg[7:1] == MIDSP_ID_ADDR) || (shift_reg[7:1] == MIDSP_DIAG_ADDR);

    // Serial protocol engine and data line drive
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            tx_shift_reg <= 8'h00;
            sda_oe_reg   <= 1'b0;
            ack_ok_reg   <= 1'b0;
        end
        else if (start_det)
        begin
            state_reg   <= ST_DEV;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    sda_oe_reg <= 1'b0;
                end
                ST_DEV, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_reg   <= {shift_reg[6:0], sda_sync_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (dev_done)
                    begin
                        state_reg  <= addr_hit ? ST_DEV_ACK : ST_IDLE;
                        sda_oe_reg <= addr_hit;
                    end
                    else if (rx_done)
                    begin
                        state_reg  <= ST_RX_ACK;
                        sda_oe_reg <= 1'b1;
                    end
                end
                ST_DEV_ACK, ST_RX_ACK, ST_TX_ACK:
                begin
                    if (scl_rise && state_reg == ST_TX_ACK)
                    begin
                        ack_ok_reg <= ~sda_sync_reg;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if ((state_reg == ST_DEV_ACK && shift_reg[0]) ||
                            (state_reg == ST_TX_ACK && ack_ok_reg))
                        begin
                            state_reg    <= ST_TX;
                            tx_shift_reg <= rd_byte;
                            sda_oe_reg   <= ~rd_byte[7];
                        end
                        else
                        begin
                            state_reg  <= (state_reg == ST_TX_ACK) ? ST_IDLE : ST_RX;
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                ST_TX:
                begin
                    if (tx_done)
                    begin
                        state_reg  <= ST_TX_ACK;
                        sda_oe_reg <= 1'b0;
                    end
                    else if (scl_fall)
                    begin
                        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                        sda_oe_reg   <= ~tx_shift_reg[6];
                        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // Page select and byte pointer
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ptr_reg      <= 8'h00;
            sel_diag_reg <= 1'b0;
            first_reg    <= 1'b0;
        end
        else if (dev_done && addr_hit)
        begin
            sel_diag_reg <= shift_reg[1];
            first_reg    <= ~shift_reg[0];
        end
        else if (rx_done && first_reg)
        begin
            ptr_reg   <= shift_reg;
            first_reg <= 1'b0;
        end
        else if (rx_done || tx_done)
        begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    // Write port: factory load first, then unprotected serial writes
    always_comb
    begin
        wr = prog_i;
        if (!prog_i.we)
        begin
            wr.we   = rx_done && !first_reg && (ptr_reg >= MIDSP_WP_LIMIT);
            wr.addr = {sel_diag_reg, ptr_reg};
            wr.data = shift_reg;
        end
    end

    midsp_mem u_mem
    (
        .clk   (clk),
        .wr    (wr),
        .raddr ({sel_diag_reg, ptr_reg}),
        .rdata (mem_rdata)
    );

    // Readings frozen while a transaction runs, so words never tear
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            live_reg    <= '0;
            cal_ext_reg <= 1'b0;
        end
        else
        begin
            cal_ext_reg <= cal_ext_i;
            if (state_reg == ST_IDLE || start_det)
            begin
                live_reg <= diag_i;
            end
        end
    end

    assign live_arr = live_reg;

    for (genvar gp = 0; gp < MIDSP_NPAR; gp++)
    begin : g_cmp
        assign ahi_w[gp] = live_arr[gp] > MIDSP_THR[gp][0];
        assign alo_w[gp] = live_arr[gp] < MIDSP_THR[gp][1];
        assign whi_w[gp] = live_arr[gp] > MIDSP_THR[gp][2];
        assign wlo_w[gp] = live_arr[gp] < MIDSP_THR[gp][3];
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            flags_reg <= '0;
        end
        else
        begin
            flags_reg <= '{ahi_w, alo_w, whi_w, wlo_w};
        end
    end

    assign alarm_bytes = flag_pair(flags_reg.alarm_hi, flags_reg.alarm_lo);
    assign warn_bytes  = flag_pair(flags_reg.warn_hi, flags_reg.warn_lo);

    // Byte returned for the current pointer
    always_comb
    begin
        rd_byte = 8'h00;
        if (!sel_diag_reg || ptr_reg >= MIDSP_WP_LIMIT)
        begin
            rd_byte = mem_rdata;
        end
        else if (ptr_reg < MIDSP_THR_END)
        begin
            rd_byte = word_byte(MIDSP_THR[ptr_reg[5:3]][ptr_reg[2:1]], ptr_reg[0]);
        end
        else if (ptr_reg >= MIDSP_LIVE_BASE && ptr_reg < MIDSP_LIVE_END)
        begin
            rd_byte = word_byte(live_arr[3'(ptr_reg[3:1])], ptr_reg[0]);
        end
        else if (ptr_reg == MIDSP_STATUS_OFF)
        begin
            rd_byte[MIDSP_CAL_BIT] = cal_ext_reg;
        end
        else if (ptr_reg[7:1] == MIDSP_ALARM_OFF[7:1])
        begin
            rd_byte = word_byte(alarm_bytes, ptr_reg[0]);
        end
        else if (ptr_reg[7:1] == MIDSP_WARN_OFF[7:1])
        begin
            rd_byte = word_byte(warn_bytes, ptr_reg[0]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            sda_o_reg     <= 1'b0;
            present_n_reg <= 1'b0;
        end
        else
        begin
            sda_o_reg     <= 1'b0;
            present_n_reg <= 1'b0;
        end
    end

    assign sda_o     = sda_o_reg;
    assign sda_oe    = sda_oe_reg;
    assign present_n = present_n_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    drive_timing_a: assert property ($changed(sda_oe_reg) |-> $past(scl_fall | start_det | stop_det))
        else $error("data drive changed away from a falling clock edge");
    id_addr_ack_a: assert property (dev_done && shift_reg[7:1] == MIDSP_ID_ADDR
                                    |=> sda_oe_reg && state_reg == ST_DEV_ACK && !sel_diag_reg)
        else $error("identification address not acknowledged");
    diag_addr_ack_a: assert property (dev_done && shift_reg[7:1] == MIDSP_DIAG_ADDR
                                      |=> sda_oe_reg && sel_diag_reg)
        else $error("diagnostic address not acknowledged");
    foreign_addr_a: assert property (dev_done && !addr_hit |=> !sda_oe_reg && state_reg == ST_IDLE)
        else $error("foreign address acknowledged");
    write_protect_a: assert property (wr.we && !prog_i.we |-> wr.addr[7] && state_reg == ST_RX)
        else $error("write into protected segment");
    ptr_wrap_a: assert property ((rx_done && !first_reg || tx_done) && ptr_reg == 8'hFF |=> ptr_reg == 8'h00)
        else $error("pointer failed to wrap");
    ptr_step_a: assert property (tx_done |=> ptr_reg == $past(ptr_reg) + 8'h01 ##1 $stable(ptr_reg))
        else $error("pointer did not advance after byte");
    presence_low_a: assert property (!present_n && !sda_o)
        else $error("presence or data value not held low");
    stop_release_a: assert property (stop_det |=> !sda_oe_reg && state_reg == ST_IDLE)
        else $error("line not released on stop");
    snapshot_a: assert property (start_det |=> live_reg == $past(diag_i))
        else $error("readings not captured at start");
    flag_alarm_a: assert property (live_reg.temp > MIDSP_THR[0][0] |=> flags_reg.alarm_hi[0])
        else $error("temperature alarm not raised");

    id_read_c: cover property (state_reg == ST_DEV_ACK && !sel_diag_reg ##[1:400] state_reg == ST_TX);
    diag_read_c: cover property (tx_done && sel_diag_reg && ptr_reg == MIDSP_LIVE_BASE);
    user_write_c: cover property (wr.we && !prog_i.we && sel_diag_reg);
    wrap_c: cover property (tx_done && ptr_reg == 8'hFF);

endmodule // midsp_top

// >>> shared/midsp_pkg.sv
package midsp_pkg;

    // Target addresses, upper seven bits of the address byte
    localparam logic [6:0] MIDSP_ID_ADDR   = 7'h50;
    localparam logic [6:0] MIDSP_DIAG_ADDR = 7'h51;

    // Two 256-byte pages in one memory, page select is the top bit
    localparam int         MIDSP_MEM_AW    = 9;
    localparam int         MIDSP_MEM_DEPTH = 512;

    // Offsets within a page; below MIDSP_WP_LIMIT is write-protected
    localparam logic [7:0] MIDSP_WP_LIMIT   = 8'h80;
    localparam logic [7:0] MIDSP_THR_END    = 8'h28;
    localparam logic [7:0] MIDSP_LIVE_BASE  = 8'h60;
    localparam logic [7:0] MIDSP_LIVE_END   = 8'h6A;
    localparam logic [7:0] MIDSP_STATUS_OFF = 8'h6E;
    localparam logic [7:0] MIDSP_ALARM_OFF  = 8'h70;
    localparam logic [7:0] MIDSP_WARN_OFF   = 8'h74;
    localparam int         MIDSP_CAL_BIT    = 0;

    localparam logic [3:0] MIDSP_BITS_BYTE  = 4'h8;
    localparam logic [3:0] MIDSP_LAST_BIT   = 4'h7;

    localparam int         MIDSP_NPAR = 5;

    // Factory limits per reading: alarm high, alarm low, warn high, warn low
    localparam logic [0:4][0:3][15:0] MIDSP_THR = '{
        '{16'h5000, 16'h0A00, 16'h4B00, 16'h0F00},   // Temperature
        '{16'h9088, 16'h7148, 16'h8CA0, 16'h7530},   // Supply voltage
        '{16'h7530, 16'h01F4, 16'h6D60, 16'h03E8},   // Laser bias
        '{16'h2710, 16'h03E8, 16'h2328, 16'h04E2},   // Transmit power
        '{16'h1F40, 16'h0005, 16'h1B58, 16'h000A}    // Receive power
    };

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] vcc;
        logic [15:0] bias;
        logic [15:0] txp;
        logic [15:0] rxp;
    } midsp_diag_t;

    typedef struct packed {
        logic [0:4] alarm_hi;
        logic [0:4] alarm_lo;
        logic [0:4] warn_hi;
        logic [0:4] warn_lo;
    } midsp_flags_t;

    typedef struct packed {
        logic                    we;
        logic [MIDSP_MEM_AW-1:0] addr;
        logic [7:0]              data;
    } midsp_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } midsp_state_t;

endpackage
